// File: src/jifp_top.sv
// Test-port indirect flash programmer: scan chain, indirect registers, flash sequencing
`timescale 1ns/10ps
module jifp_top #(
  parameter logic [15:0] LOCK_READ_ADDR  = 16'hFFFE,
  parameter logic [15:0] LOCK_WRITE_ADDR = 16'hFFFF
) (
  input  wire logic                 core_clk,
  input  wire logic                 reset,
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdo_en,
  output jifp_pkg::jifp_freq_s      flash_req,
  input  wire jifp_pkg::jifp_frsp_s flash_rsp,
  output logic                      busy
);

  // Pin synchronisation and edge finding
  jifp_pkg::jifp_pins_s pins_raw;
  jifp_pkg::jifp_pins_s pins;
  logic                 tck_prev_r;
  logic                 tck_rise;
  logic                 tck_fall;

  assign pins_raw = '{tdi: tdi, tms: tms, tck: tck};

  jifp_sync #(
    .W ($bits(jifp_pkg::jifp_pins_s))
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .pin_in   (pins_raw),
    .pin_out  (pins)
  );

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tck_prev_r <= 1'b1;
    end else begin
      tck_prev_r <= pins.tck;
    end
  end

  assign tck_rise = pins.tck & ~tck_prev_r;
  assign tck_fall = ~pins.tck & tck_prev_r;

  // Port controller
  jifp_pkg::jifp_tap_e tap;

  jifp_tap u_tap (
    .core_clk (core_clk),
    .reset    (reset),
    .tck_rise (tck_rise),
    .tms      (pins.tms),
    .state_r  (tap)
  );

  // Instruction register
  logic [jifp_pkg::IR_W-1:0] ir_r;
  logic [jifp_pkg::IR_W-1:0] ir_sh_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ir_r    <= jifp_pkg::IR_RESET;
      ir_sh_r <= jifp_pkg::IR_RESET;
    end else if (tck_rise) begin
      if (tap == jifp_pkg::TAP_TLR) begin
        ir_r <= jifp_pkg::IR_RESET;
      end
      if (tap == jifp_pkg::TAP_CAP_IR) begin
        ir_sh_r <= jifp_pkg::IR_CAPTURE;
      end
      if (tap == jifp_pkg::TAP_SHF_IR) begin
        ir_sh_r <= {pins.tdi, ir_sh_r[jifp_pkg::IR_W-1:1]};
      end
      if (tap == jifp_pkg::TAP_UPD_IR) begin
        ir_r <= ir_sh_r;
      end
    end
  end

  // Indirect register selection
  logic       sel_ctl;
  logic       sel_dat;
  logic       sel_adr;
  logic       sel_ind;
  logic [1:0] selected_reg_index;

  assign sel_ctl = (ir_r == jifp_pkg::IR_FLASH_CTL); // see RULE21
  assign sel_dat = (ir_r == jifp_pkg::IR_FLASH_DAT); // see RULE21
  assign sel_adr = (ir_r == jifp_pkg::IR_FLASH_ADR); // see RULE21
  assign sel_ind = sel_ctl | sel_dat | sel_adr;
  assign selected_reg_index = {sel_adr, sel_dat};

  // Data shift path; non-indirect codes see a one-bit bypass
  logic [jifp_pkg::DR_W-1:0]  dr_sh_r;
  logic [jifp_pkg::PAY_W-1:0] read_payload_r;
  logic [jifp_pkg::DR_W-1:0]  capture_word;

  assign capture_word = {1'b0, read_payload_r, busy}; // see RULE7

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dr_sh_r <= '0;
    end else if (tck_rise) begin
      if (tap == jifp_pkg::TAP_CAP_DR) begin
        dr_sh_r <= sel_ind ? capture_word : '0;
      end else if (tap == jifp_pkg::TAP_SHF_DR) begin
        dr_sh_r <= sel_ind ? {pins.tdi, dr_sh_r[jifp_pkg::DR_W-1:1]}
                           : {{(jifp_pkg::DR_W-1){1'b0}}, pins.tdi};
      end
    end
  end

  // Command decode at update
  logic [1:0] indirect_op_field;
  logic [jifp_pkg::PAY_W-1:0] write_payload;
  logic       upd_pulse;
  logic       is_poll;
  logic       is_rd;
  logic       is_wr;
  logic       cmd_go;

  assign indirect_op_field = dr_sh_r[jifp_pkg::OP_HI:jifp_pkg::OP_LO]; // see RULE1
  assign write_payload     = dr_sh_r[jifp_pkg::PAY_W-1:0];             // see RULE1
  assign upd_pulse = tck_rise & (tap == jifp_pkg::TAP_UPD_DR) & sel_ind;
  assign is_poll   = ~indirect_op_field[1];                             // see RULE2
  assign is_rd     = (indirect_op_field == jifp_pkg::OP_READ);          // see RULE2
  assign is_wr     = (indirect_op_field == jifp_pkg::OP_WRITE);         // see RULE2
  // Polls never act; read or write only when idle
  assign cmd_go    = upd_pulse & ~is_poll & ~busy;                      // see RULE3 see RULE4 see RULE9

  // Held registers
  logic [jifp_pkg::CTL_W-1:0]  flash_control_reg;
  logic [jifp_pkg::BYTE_W-1:0] dat_byte_r;
  logic                        fail_r;
  logic [jifp_pkg::ADR_W-1:0]  flash_address_reg;
  logic                        collected_r;
  logic [jifp_pkg::DAT_W-1:0]  flash_data_reg;

  assign flash_data_reg = {dat_byte_r, fail_r, busy}; // see RULE19

  // Behaviour fields and left-justified write fields
  logic                        scratchpad_select;
  logic [2:0]                  write_behavior_sel;
  logic [3:0]                  read_behavior_sel;
  logic [jifp_pkg::BYTE_W-1:0] wr_byte;
  logic [jifp_pkg::ADR_W-1:0]  wr_addr;

  assign scratchpad_select  = flash_control_reg[jifp_pkg::SCRATCH_BIT];
  assign write_behavior_sel = flash_control_reg[jifp_pkg::WRMD_HI:jifp_pkg::WRMD_LO];
  assign read_behavior_sel  = flash_control_reg[jifp_pkg::RDMD_HI:jifp_pkg::RDMD_LO];
  assign wr_byte = write_payload[jifp_pkg::PAY_W-1 -: jifp_pkg::BYTE_W];
  assign wr_addr = write_payload[jifp_pkg::PAY_W-1 -: jifp_pkg::ADR_W];

  // Operation decode
  logic ctl_wr;
  logic adr_wr;
  logic dat_wr;
  logic dat_rd;
  logic prog_go;
  logic erase_go;
  logic lock_hit;
  logic read_go;
  logic flash_go;
  logic flash_end;
  logic end_rd;
  logic end_inc;

  assign ctl_wr   = cmd_go & is_wr & sel_ctl;
  assign adr_wr   = cmd_go & is_wr & sel_adr;
  assign dat_wr   = cmd_go & is_wr & sel_dat;
  assign dat_rd   = cmd_go & is_rd & sel_dat;
  assign prog_go  = dat_wr & (write_behavior_sel == jifp_pkg::WRMD_PROG);  // see RULE13
  assign erase_go = dat_wr & (write_behavior_sel == jifp_pkg::WRMD_ERASE)
                  & (wr_byte == jifp_pkg::ERASE_KEY);                      // see RULE14
  assign lock_hit = (flash_address_reg == LOCK_READ_ADDR)
                  | (flash_address_reg == LOCK_WRITE_ADDR);                // see RULE15
  assign read_go  = dat_rd & ((read_behavior_sel == jifp_pkg::RDMD_BLOCK)
                  | ((read_behavior_sel == jifp_pkg::RDMD_SINGLE) & collected_r)); // see RULE17 see RULE18
  assign flash_go = prog_go | erase_go | read_go;

  // Sequencer
  jifp_pkg::jifp_eng_e eng_r;
  jifp_pkg::jifp_eng_e eng_nxt;

  always_comb begin
    unique case (eng_r)
      jifp_pkg::ENG_IDLE:  eng_nxt = flash_go ? jifp_pkg::ENG_FLASH
                                   : (cmd_go ? jifp_pkg::ENG_LOCAL : jifp_pkg::ENG_IDLE);
      jifp_pkg::ENG_LOCAL: eng_nxt = jifp_pkg::ENG_IDLE;
      jifp_pkg::ENG_FLASH: eng_nxt = flash_rsp.done ? jifp_pkg::ENG_IDLE : jifp_pkg::ENG_FLASH;
      default:             eng_nxt = jifp_pkg::ENG_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      eng_r <= jifp_pkg::ENG_IDLE;
    end else begin
      eng_r <= eng_nxt;
    end
  end

  assign busy      = (eng_r != jifp_pkg::ENG_IDLE);                // see RULE8
  assign flash_end = (eng_r == jifp_pkg::ENG_FLASH) & flash_rsp.done;
  assign end_rd    = flash_end & (flash_req.cmd == jifp_pkg::FCMD_READ);
  assign end_inc   = end_rd | (flash_end & (flash_req.cmd == jifp_pkg::FCMD_PROG));

  // Read result, right-justified above busy
  logic [jifp_pkg::PAY_W-1:0] rd_value;

  assign rd_value = selected_reg_index[1] ? jifp_pkg::PAY_W'(flash_address_reg)
                  : selected_reg_index[0] ? jifp_pkg::PAY_W'(flash_data_reg)
                  : jifp_pkg::PAY_W'(flash_control_reg);            // see RULE10 see RULE16

  always_ff @(posedge core_clk) begin
    if (reset) begin
      read_payload_r <= '0;
    end else if (cmd_go & is_rd) begin
      read_payload_r <= rd_value;                                  // see RULE10
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flash_control_reg <= jifp_pkg::CTL_RESET;
    end else if (ctl_wr) begin
      flash_control_reg <= wr_byte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flash_address_reg <= jifp_pkg::ADR_RESET;
    end else if (adr_wr) begin
      flash_address_reg <= wr_addr;
    end else if (end_inc) begin
      flash_address_reg <= flash_address_reg + jifp_pkg::ADR_STEP;  // see RULE13 see RULE20
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      dat_byte_r <= jifp_pkg::DAT_RESET;
    end else if (dat_wr) begin
      dat_byte_r <= wr_byte;                                       // see RULE12
    end else if (end_rd) begin
      dat_byte_r <= flash_rsp.rdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      fail_r <= 1'b0;
    end else if (flash_end) begin
      fail_r <= flash_rsp.fail;                                    // see RULE22
    end
  end

  // A fresh byte counts as collected once a data read returns it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      collected_r <= 1'b1;
    end else if (dat_rd) begin
      collected_r <= 1'b1;
    end else if (end_rd) begin
      collected_r <= 1'b0;
    end
  end

  // Flash request
  jifp_pkg::jifp_fcmd_e fcmd_nxt;

  assign fcmd_nxt = read_go ? jifp_pkg::FCMD_READ
                  : prog_go ? jifp_pkg::FCMD_PROG
                  : lock_hit ? jifp_pkg::FCMD_MASS                  // see RULE15
                  : jifp_pkg::FCMD_ERASE;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      flash_req <= '0;
    end else begin
      flash_req.start <= flash_go & (eng_r == jifp_pkg::ENG_IDLE);
      if (flash_go) begin
        flash_req.cmd     <= fcmd_nxt;
        flash_req.scratch <= scratchpad_select;                    // see RULE11
        flash_req.addr    <= flash_address_reg;
        flash_req.wdata   <= wr_byte;
      end
    end
  end

  // Serial output changes on falling clock edges
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tdo    <= 1'b0;
      tdo_en <= 1'b0;
    end else if (tck_fall) begin
      tdo    <= (tap == jifp_pkg::TAP_SHF_IR) ? ir_sh_r[0] : dr_sh_r[jifp_pkg::BUSY_POS];
      tdo_en <= (tap == jifp_pkg::TAP_SHF_IR) | (tap == jifp_pkg::TAP_SHF_DR);
    end
  end

  // Checks
  AST_POLL_QUIET: assert property (@(posedge core_clk) disable iff (reset) // see RULE3
    (upd_pulse && is_poll) |=> (eng_r == $past(eng_r) || $past(eng_r) != jifp_pkg::ENG_IDLE))
    else $error("poll started an operation");

  AST_START_BUSY: assert property (@(posedge core_clk) disable iff (reset) // see RULE8
    cmd_go |=> busy)
    else $error("busy not set at start");

  AST_LOCAL_DONE: assert property (@(posedge core_clk) disable iff (reset) // see RULE8
    (eng_r == jifp_pkg::ENG_LOCAL) |=> !busy)
    else $error("register access did not complete");

  AST_BUSY_BLOCKS: assert property (@(posedge core_clk) disable iff (reset) // see RULE9
    (busy && upd_pulse && !is_poll) |=> !flash_req.start && $stable(flash_control_reg))
    else $error("command accepted while busy");

  AST_CAPTURE_FMT: assert property (@(posedge core_clk) disable iff (reset) // see RULE7
    (tck_rise && tap == jifp_pkg::TAP_CAP_DR && sel_ind)
    |=> !dr_sh_r[jifp_pkg::DR_W-1] && dr_sh_r[jifp_pkg::BUSY_POS] == $past(busy))
    else $error("captured status word malformed");

  AST_MODE0_NO_FLASH: assert property (@(posedge core_clk) disable iff (reset) // see RULE12
    (dat_wr && write_behavior_sel == jifp_pkg::WRMD_NONE) |=> !flash_req.start ##1 !busy)
    else $error("write mode zero touched flash");

  AST_ERASE_KEY: assert property (@(posedge core_clk) disable iff (reset) // see RULE14
    (dat_wr && write_behavior_sel == jifp_pkg::WRMD_ERASE && wr_byte != jifp_pkg::ERASE_KEY)
    |=> !flash_req.start)
    else $error("erase without key");

  AST_MASS_ERASE: assert property (@(posedge core_clk) disable iff (reset) // see RULE15
    (erase_go && lock_hit) |=> flash_req.start && flash_req.cmd == jifp_pkg::FCMD_MASS)
    else $error("lock byte erase not widened");

  AST_ADDR_INC: assert property (@(posedge core_clk) disable iff (reset) // see RULE20
    end_inc |=> flash_address_reg == jifp_pkg::ADR_W'($past(flash_address_reg) + jifp_pkg::ADR_STEP))
    else $error("address not incremented");

  AST_ERASE_ADDR: assert property (@(posedge core_clk) disable iff (reset) // see RULE14
    (flash_end && flash_req.cmd inside {jifp_pkg::FCMD_ERASE, jifp_pkg::FCMD_MASS}) |=> $stable(flash_address_reg))
    else $error("erase moved the address");

  AST_SINGLE_READ: assert property (@(posedge core_clk) disable iff (reset) // see RULE18
    (dat_rd && read_behavior_sel == jifp_pkg::RDMD_SINGLE && !collected_r) |=> !flash_req.start)
    else $error("single read restarted early");

  AST_FAIL_FLAG: assert property (@(posedge core_clk) disable iff (reset) // see RULE22
    flash_end |=> fail_r == $past(flash_rsp.fail) && !busy)
    else $error("fail flag not updated");

endmodule : jifp_top

// File: src/jifp_pkg.sv
// Package of constants and types for the test-port flash programmer
// Notes on behaviour
// RULE1: Command is 20 bits: opcode 19:18, payload 17:0
// RULE2: Opcode 0x polls, 10 reads, 11 writes
// RULE3: Poll captures status and suppresses any update
// RULE4: Read starts after only two opcode bits shifted
// RULE5: Host left-justifies short payloads at bit 17
// RULE6: Host keeps instruction unchanged while operation busy
// RULE7: Outgoing: bit19 zero, data 18:1, busy 0
// RULE8: Busy sets on start, clears on completion
// RULE9: Commands ignored while busy, accepted once idle
// RULE10: Read data right-justified just above busy
// RULE11: Control bit 7 steers accesses to scratchpad
// RULE12: Write mode 000 only updates data register
// RULE13: Write mode 001 programs byte, then increments
// RULE14: Write mode 010 with A5 erases page
// RULE15: Erase at lock byte erases whole user space
// RULE16: Read mode 0000 returns held data only
// RULE17: Read mode 0001 starts read when idle
// RULE18: Read mode 0010 also needs previous data collected
// RULE19: Data register: byte 9:2, fail 1, busy 0
// RULE20: Address increments after every read or program
// RULE21: Codes 0082/0083/0084 select control, data, address
// RULE22: Fail flag reflects latest completed flash operation
package jifp_pkg;

  localparam int IR_W   = 16;
  localparam int DR_W   = 20;
  localparam int PAY_W  = 18;
  localparam int CTL_W  = 8;
  localparam int DAT_W  = 10;
  localparam int ADR_W  = 16;
  localparam int BYTE_W = 8;

  localparam logic [IR_W-1:0] IR_RESET     = 16'h0000;
  localparam logic [IR_W-1:0] IR_CAPTURE   = 16'h0001;
  localparam logic [IR_W-1:0] IR_FLASH_CTL = 16'h0082;
  localparam logic [IR_W-1:0] IR_FLASH_DAT = 16'h0083;
  localparam logic [IR_W-1:0] IR_FLASH_ADR = 16'h0084;

  localparam int OP_HI    = 19;
  localparam int OP_LO    = 18;
  localparam int BUSY_POS = 0;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h3;

  localparam int SCRATCH_BIT = 7;
  localparam int WRMD_HI     = 6;
  localparam int WRMD_LO     = 4;
  localparam int RDMD_HI     = 3;
  localparam int RDMD_LO     = 0;
  localparam logic [2:0] WRMD_NONE   = 3'h0;
  localparam logic [2:0] WRMD_PROG   = 3'h1;
  localparam logic [2:0] WRMD_ERASE  = 3'h2;
  localparam logic [3:0] RDMD_NONE   = 4'h0;
  localparam logic [3:0] RDMD_BLOCK  = 4'h1;
  localparam logic [3:0] RDMD_SINGLE = 4'h2;

  localparam logic [BYTE_W-1:0] ERASE_KEY = 8'hA5;
  localparam logic [CTL_W-1:0]  CTL_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] DAT_RESET = 8'h00;
  localparam logic [ADR_W-1:0]  ADR_RESET = 16'h0000;
  localparam logic [ADR_W-1:0]  ADR_STEP  = 16'h0001;

  typedef enum logic [15:0] {
    TAP_TLR    = 16'h0001, TAP_RTI    = 16'h0002, TAP_SEL_DR = 16'h0004, TAP_CAP_DR = 16'h0008,
    TAP_SHF_DR = 16'h0010, TAP_EX1_DR = 16'h0020, TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100, TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SHF_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000, TAP_UPD_IR = 16'h8000
  } jifp_tap_e;

  typedef enum logic [2:0] {
    ENG_IDLE  = 3'h1,
    ENG_LOCAL = 3'h2,
    ENG_FLASH = 3'h4
  } jifp_eng_e;

  typedef enum logic [1:0] {
    FCMD_READ  = 2'h0,
    FCMD_PROG  = 2'h1,
    FCMD_ERASE = 2'h2,
    FCMD_MASS  = 2'h3
  } jifp_fcmd_e;

  typedef struct packed {
    logic              start;
    jifp_fcmd_e        cmd;
    logic              scratch;
    logic [ADR_W-1:0]  addr;
    logic [BYTE_W-1:0] wdata;
  } jifp_freq_s;

  typedef struct packed {
    logic              done;
    logic              fail;
    logic [BYTE_W-1:0] rdata;
  } jifp_frsp_s;

  typedef struct packed {
    logic tdi;
    logic tms;
    logic tck;
  } jifp_pins_s;

endpackage : jifp_pkg

// File: src/jifp_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module jifp_sync #(
  parameter int W = 3
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);

  logic [W-1:0] q1_r;
  logic [W-1:0] q2_r;
  logic [W-1:0] q3_r;
  logic [W-1:0] out_nxt;

  // Accept a new level only where stages two and three agree
  assign out_nxt = (q2_r & ~(q2_r ^ q3_r)) | (pin_out & (q2_r ^ q3_r));

  // Stages reset to the pins' idle high level, so no false edge follows reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q1_r    <= '1;
      q2_r    <= '1;
      q3_r    <= '1;
      pin_out <= '1;
    end else begin
      q1_r    <= pin_in;
      q2_r    <= q1_r;
      q3_r    <= q2_r;
      pin_out <= out_nxt;
    end
  end

endmodule : jifp_sync

// File: src/jifp_tap.sv
// Test access port state machine stepped by detected clock edges
`timescale 1ns/10ps
module jifp_tap (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               tck_rise,
  input  wire logic               tms,
  output jifp_pkg::jifp_tap_e     state_r
);

  jifp_pkg::jifp_tap_e state_nxt;

  always_comb begin
    unique case (state_r)
      jifp_pkg::TAP_TLR:    state_nxt = tms ? jifp_pkg::TAP_TLR    : jifp_pkg::TAP_RTI;
      jifp_pkg::TAP_RTI:    state_nxt = tms ? jifp_pkg::TAP_SEL_DR : jifp_pkg::TAP_RTI;
      jifp_pkg::TAP_SEL_DR: state_nxt = tms ? jifp_pkg::TAP_SEL_IR : jifp_pkg::TAP_CAP_DR;
      jifp_pkg::TAP_CAP_DR: state_nxt = tms ? jifp_pkg::TAP_EX1_DR : jifp_pkg::TAP_SHF_DR;
      jifp_pkg::TAP_SHF_DR: state_nxt = tms ? jifp_pkg::TAP_EX1_DR : jifp_pkg::TAP_SHF_DR;
      jifp_pkg::TAP_EX1_DR: state_nxt = tms ? jifp_pkg::TAP_UPD_DR : jifp_pkg::TAP_PAU_DR;
      jifp_pkg::TAP_PAU_DR: state_nxt = tms ? jifp_pkg::TAP_EX2_DR : jifp_pkg::TAP_PAU_DR;
      jifp_pkg::TAP_EX2_DR: state_nxt = tms ? jifp_pkg::TAP_UPD_DR : jifp_pkg::TAP_SHF_DR;
      jifp_pkg::TAP_UPD_DR: state_nxt = tms ? jifp_pkg::TAP_SEL_DR : jifp_pkg::TAP_RTI;
      jifp_pkg::TAP_SEL_IR: state_nxt = tms ? jifp_pkg::TAP_TLR    : jifp_pkg::TAP_CAP_IR;
      jifp_pkg::TAP_CAP_IR: state_nxt = tms ? jifp_pkg::TAP_EX1_IR : jifp_pkg::TAP_SHF_IR;
      jifp_pkg::TAP_SHF_IR: state_nxt = tms ? jifp_pkg::TAP_EX1_IR : jifp_pkg::TAP_SHF_IR;
      jifp_pkg::TAP_EX1_IR: state_nxt = tms ? jifp_pkg::TAP_UPD_IR : jifp_pkg::TAP_PAU_IR;
      jifp_pkg::TAP_PAU_IR: state_nxt = tms ? jifp_pkg::TAP_EX2_IR : jifp_pkg::TAP_PAU_IR;
      jifp_pkg::TAP_EX2_IR: state_nxt = tms ? jifp_pkg::TAP_UPD_IR : jifp_pkg::TAP_SHF_IR;
      jifp_pkg::TAP_UPD_IR: state_nxt = tms ? jifp_pkg::TAP_SEL_DR : jifp_pkg::TAP_RTI;
      default:              state_nxt = jifp_pkg::TAP_TLR;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= jifp_pkg::TAP_TLR;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

endmodule : jifp_tap

// File: tb/jifp_flash_model.sv
// Behavioural flash array answering the sequencer's requests
`timescale 1ns/10ps
module jifp_flash_model (
  input  wire logic                 core_clk,
  input  wire jifp_pkg::jifp_freq_s flash_req,
  output jifp_pkg::jifp_frsp_s      flash_rsp,
  input  wire logic [31:0]          delay
);
  logic [7:0]           mem [0:255];
  int                   starts = 0;
  logic                 scr    = 1'b0;
  jifp_pkg::jifp_fcmd_e cmd;
  logic                 bad;

  initial flash_rsp = '0;
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h00;

  // One request at a time, answered after a set delay
  always @(posedge core_clk) begin
    if (flash_req.start) begin
      starts++;
      cmd = flash_req.cmd;
      scr = flash_req.scratch;
      bad = flash_req.addr[15:12] == 4'hF && cmd == jifp_pkg::FCMD_PROG;
      repeat (delay) @(posedge core_clk);
      if (cmd == jifp_pkg::FCMD_PROG && !bad) mem[flash_req.addr[7:0]] = flash_req.wdata;
      if (cmd[1]) for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
      flash_rsp <= {1'b1, bad, mem[flash_req.addr[7:0]]};
      @(posedge core_clk);
      // Stale data is inverted once the answer is withdrawn
      flash_rsp <= {1'b0, 1'b0, ~flash_rsp.rdata};
    end
  end
endmodule : jifp_flash_model

// File: tb/jifp_bench.sv
// Self-checking bench driving the test port as an external programmer
`timescale 1ns/10ps
module jifp_bench;
  logic                 core_clk   = 1'b0;
  logic                 reset      = 1'b1;
  logic                 tck        = 1'b1;
  logic                 tms        = 1'b1;
  logic                 tdi        = 1'b0;
  logic                 tdo;
  logic                 tdo_en;
  logic                 en;
  logic                 busy;
  int                   delay      = 3;
  int                   fail_count = 0;
  int                   cmp_count  = 0;
  int                   s;
  logic [17:0]          v;
  logic [19:0]          x;
  jifp_pkg::jifp_freq_s req;
  jifp_pkg::jifp_frsp_s rsp;

  jifp_top uut (.core_clk(core_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_en(tdo_en), .flash_req(req), .flash_rsp(rsp), .busy(busy));
  jifp_flash_model mdl (.core_clk(core_clk), .flash_req(req), .flash_rsp(rsp), .delay(delay));

  initial forever #5 core_clk = ~core_clk;

  task automatic stop_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One test clock period of 170 ns, tdo taken late in the low phase
  task automatic tclk(input logic m, input logic d, output logic o);
    @(negedge core_clk);
    tms = m;
    tdi = d;
    tck = 1'b0;
    repeat (8) @(negedge core_clk);
    o = tdo;
    tck = 1'b1;
    repeat (8) @(negedge core_clk);
  endtask : tclk

  // From idle through capture, shift and update back to idle
  task automatic scan(input logic ir, input int n, input logic [19:0] din, output logic [19:0] dout);
    logic o;
    dout = '0;
    tclk(1'b1, 1'b0, o);
    if (ir) tclk(1'b1, 1'b0, o);
    tclk(1'b0, 1'b0, o);
    tclk(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tclk(i == n - 1, din[i], o);
      dout[i] = o;
      if (i == 0) en = tdo_en;
    end
    tclk(1'b1, 1'b0, o);
    tclk(1'b0, 1'b0, o);
  endtask : scan

  task automatic sel(input logic [15:0] code);
    scan(1'b1, 16, {4'h0, code}, x);
  endtask : sel

  task automatic wait_idle;
    x[0] = 1'b1;
    for (int i = 0; i < 60 && x[0] !== 1'b0; i++) scan(1'b0, 1, 20'h0, x);
    chk("idle", 18'h0, {17'h0, x[0]});
  endtask : wait_idle

  // Short write: opcode just above a right-aligned value of w bits
  task automatic wr(input int w, input logic [17:0] d, input logic go);
    scan(1'b0, w + 2, (20'h3 << w) | d, x);
    if (go) wait_idle();
  endtask : wr

  task automatic rd(input int w);
    scan(1'b0, 2, 20'h2, x);
    wait_idle();
    scan(1'b0, w + 1, 20'h0, x);
    v = x[18:1];
  endtask : rd

  task automatic setup(input logic [7:0] c, input logic [15:0] a);
    sel(jifp_pkg::IR_FLASH_CTL);
    wr(8, {10'h0, c}, 1'b1);
    sel(jifp_pkg::IR_FLASH_ADR);
    wr(16, {2'h0, a}, 1'b1);
    sel(jifp_pkg::IR_FLASH_DAT);
  endtask : setup

  initial begin
    repeat (95000) @(posedge core_clk);
    fail_count++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    for (int i = 0; i < 6; i++) tclk(i < 5, 1'b0, x[0]);
    chk("idle enable", 18'h0, {17'h0, tdo_en});
    scan(1'b0, 2, 20'h1, x);
    chk("bypass", 18'h2, x[17:0]);
    sel(jifp_pkg::IR_FLASH_CTL);
    chk("ir capture", 18'h1, x[17:0]);
    chk("shift enable", 18'h1, {17'h0, en});
    rd(8);
    chk("control", 18'h0, v);
    sel(jifp_pkg::IR_FLASH_ADR);
    rd(16);
    chk("address", 18'h0, v);
    sel(jifp_pkg::IR_FLASH_DAT);
    wr(8, 18'h55, 1'b1);
    rd(10);
    chk("data held", 18'h154, v);
    chk("starts", 18'h0, mdl.starts[17:0]);
    $display("test reset and plain modes done");
    setup(8'h10, 16'h0010);
    wr(8, 18'h3C, 1'b1);
    chk("flash byte", 18'h3C, {10'h0, mdl.mem[16]});
    setup(8'h10, 16'hF000);
    wr(8, 18'h77, 1'b1);
    rd(10);
    chk("fail flag", 18'h1DE, v);
    sel(jifp_pkg::IR_FLASH_ADR);
    rd(16);
    chk("address step", 18'hF001, v);
    $display("test program done");
    setup(8'h01, 16'h0010);
    rd(10);
    rd(10);
    chk("block read", 18'h0F0, v);
    s = mdl.starts;
    setup(8'h02, 16'h0011);
    rd(10);
    rd(10);
    chk("single reads", 18'h1, 18'(mdl.starts - s));
    $display("test read modes done");
    setup(8'h20, 16'h0010);
    s = mdl.starts;
    wr(8, 18'h11, 1'b1);
    chk("no erase", 18'h0, 18'(mdl.starts - s));
    wr(8, 18'hA5, 1'b1);
    chk("erased", 18'hFF, {10'h0, mdl.mem[16]});
    sel(jifp_pkg::IR_FLASH_ADR);
    rd(16);
    chk("address kept", 18'h0010, v);
    setup(8'h20, 16'hFFFE);
    wr(8, 18'hA5, 1'b1);
    chk("mass erase", 18'h3, {16'h0, mdl.cmd});
    $display("test erase done");
    setup(8'h90, 16'h0020);
    delay = 3000;
    s = mdl.starts;
    wr(8, 18'h42, 1'b0);
    wr(8, 18'h43, 1'b0);
    chk("busy pin", 18'h1, {17'h0, busy});
    wait_idle();
    chk("one start", 18'h1, 18'(mdl.starts - s));
    chk("scratch", 18'h1, {17'h0, mdl.scr});
    chk("kept byte", 18'h42, {10'h0, mdl.mem[32]});
    $display("test busy refusal done");
    stop_test();
  end
endmodule : jifp_bench
